// ### rtl/counter16_capture.v
// Purpose: 16-bit up/down timer counter with input capture behind an APB slave
// Assumes: Single clock pclk, external pins synchronised here
// Notes: Byte-wide registers; high-byte writes and counter/capture high-byte reads go through one shared temporary byte
`timescale 1ns/1ps
`include "counter16_defs.vh"

module counter16_capture #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ext_clock_pin,
    input wire capture_pin,
    input wire comparator_output,
    input wire overflow_irq_ack,
    input wire capture_irq_ack,
    output reg overflow_irq,
    output reg capture_irq,
    output reg at_top,
    output reg at_bottom
);

    reg [7:0] ctrl_a_reg;
    reg [7:0] ctrl_b_reg;
    reg [7:0] temp_reg;
    reg [15:0] count_reg;
    reg [15:0] count_next;
    reg [15:0] capture_reg;
    reg [15:0] cmpa_reg;
    reg [15:0] cmpb_reg;
    reg [7:0] irq_en_reg;
    reg [7:0] cap_cfg_reg;
    reg overflow_flag_reg;
    reg capture_flag_reg;
    reg dir_down_reg;
    reg dir_down_next;
    reg ovf_event;
    reg [`PRESC_W-1:0] presc_reg;
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;
    reg [2:0] sync3_reg;
    reg [2:0] level_reg;
    reg [31:0] rdata_next;
    reg mapped;
    reg [15:0] top_val;
    reg tick;
    reg dual_slope;
    reg icr_top;
    reg tov_at_max;

    wire [3:0] waveform_mode_field = {ctrl_b_reg[`B_WGM_MSB:`B_WGM_LSB], ctrl_a_reg[`A_WGM_MSB:`A_WGM_LSB]};
    wire [2:0] clock_select_field = ctrl_b_reg[`B_CS_MSB:`B_CS_LSB];
    wire [7:0] wbyte = pwdata[7:0];

    // APB phases: reads act at setup edge, writes at access edge
    wire setup_cyc = psel & ~penable & ~pready;
    wire rd_setup = setup_cyc & ~pwrite;
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;

    wire wr_cnt_lo = wr & (paddr == `OFS_CNT_LO);
    wire wr_cap_lo = wr & (paddr == `OFS_CAP_LO);
    wire wr_flags = wr & (paddr == `OFS_FLAGS);
    wire wr_hi = wr & ((paddr == `OFS_CNT_HI) | (paddr == `OFS_CAP_HI) |
                       (paddr == `OFS_CMPA_HI) | (paddr == `OFS_CMPB_HI));

    // Three-flop synchronisers for ext clock, capture pin and comparator
    wire [2:0] raw_in = {comparator_output, capture_pin, ext_clock_pin};
    wire [2:0] stable;
    wire [2:0] rise;
    wire [2:0] fall;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            // Change counts once second and third stages agree
            assign stable[gi] = (sync2_reg[gi] == sync3_reg[gi]) & (sync3_reg[gi] != level_reg[gi]);
            assign rise[gi] = stable[gi] & sync3_reg[gi];
            assign fall[gi] = stable[gi] & ~sync3_reg[gi];
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                    sync3_reg[gi] <= 1'b0;
                    level_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= raw_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (stable[gi]) begin
                        level_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // Capture source and edge selection
    wire src_cmp = cap_cfg_reg[`CFG_SRC_BIT];
    wire edge_rise = ctrl_b_reg[`B_EDGE_BIT];
    wire sel_rise = src_cmp ? rise[2] : rise[1];
    wire sel_fall = src_cmp ? fall[2] : fall[1];
    wire capture_event = ~icr_top & (edge_rise ? sel_rise : sel_fall);

    // Free-running prescaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= {`PRESC_W{1'b0}};
        end else begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    // Timer clock select
    always @* begin
        case (clock_select_field)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = &presc_reg[2:0];
            3'h3: tick = &presc_reg[5:0];
            3'h4: tick = &presc_reg[7:0];
            3'h5: tick = &presc_reg[9:0];
            3'h6: tick = fall[0];
            3'h7: tick = rise[0];
            default: tick = 1'b0;
        endcase
    end

    // Top value and sequence class per waveform mode
    always @* begin
        case (waveform_mode_field)
            4'h1, 4'h5: top_val = `TOP_8BIT;
            4'h2, 4'h6: top_val = `TOP_9BIT;
            4'h3, 4'h7: top_val = `TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_val = cmpa_reg;
            4'h8, 4'hA, 4'hC, 4'hE: top_val = capture_reg;
            default: top_val = `CNT_MAX;
        endcase
        case (waveform_mode_field)
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: dual_slope = 1'b1;
            default: dual_slope = 1'b0;
        endcase
        case (waveform_mode_field)
            4'h8, 4'hA, 4'hC, 4'hE: icr_top = 1'b1;
            default: icr_top = 1'b0;
        endcase
        case (waveform_mode_field)
            4'h0, 4'h4, 4'hC: tov_at_max = 1'b1;
            default: tov_at_max = 1'b0;
        endcase
    end

    // Counter next state, software write has priority
    always @* begin
        count_next = count_reg;
        dir_down_next = dual_slope ? dir_down_reg : 1'b0;
        ovf_event = 1'b0;
        if (wr_cnt_lo) begin
            count_next = {temp_reg, wbyte};
        end else if (tick) begin
            if (dual_slope) begin
                if (!dir_down_reg) begin
                    if (count_reg >= top_val) begin
                        dir_down_next = 1'b1;
                        count_next = count_reg - 16'h0001;
                    end else begin
                        count_next = count_reg + 16'h0001;
                    end
                end else if (count_reg == `CNT_RST) begin
                    dir_down_next = 1'b0;
                    count_next = count_reg + 16'h0001;
                    ovf_event = 1'b1;
                end else begin
                    count_next = count_reg - 16'h0001;
                end
            end else begin
                if (count_reg == top_val) begin
                    count_next = `CNT_RST;
                end else begin
                    count_next = count_reg + 16'h0001;
                end
                ovf_event = tov_at_max ? (count_reg == `CNT_MAX) : (count_reg == top_val);
            end
        end
    end

    // Counter, direction and position indications
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `CNT_RST;
            dir_down_reg <= 1'b0;
            at_top <= 1'b0;
            at_bottom <= 1'b1;
        end else begin
            count_reg <= count_next;
            dir_down_reg <= dir_down_next;
            at_top <= (count_next == top_val);
            at_bottom <= (count_next == `CNT_RST);
        end
    end

    // Shared temporary high byte
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_reg <= `CTRL_RST;
        end else if (wr_hi) begin
            temp_reg <= wbyte;
        end else if (rd_setup && (paddr == `OFS_CNT_LO)) begin
            temp_reg <= count_reg[15:8];
        end else if (rd_setup && (paddr == `OFS_CAP_LO)) begin
            temp_reg <= capture_reg[15:8];
        end
    end

    // Capture register: event copy, or software write in top modes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_reg <= `CNT_RST;
        end else if (capture_event) begin
            capture_reg <= count_reg;
        end else if (wr_cap_lo && icr_top) begin
            capture_reg <= {temp_reg, wbyte};
        end
    end

    // Flags: hardware set wins over clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_reg <= 1'b0;
            capture_flag_reg <= 1'b0;
        end else begin
            if (ovf_event) begin
                overflow_flag_reg <= 1'b1;
            end else if (overflow_irq_ack || (wr_flags && wbyte[`FLAG_OVF_BIT])) begin
                overflow_flag_reg <= 1'b0;
            end
            if (capture_event) begin
                capture_flag_reg <= 1'b1;
            end else if (capture_irq_ack || (wr_flags && wbyte[`FLAG_CAP_BIT])) begin
                capture_flag_reg <= 1'b0;
            end
        end
    end

    // Interrupt requests
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq <= 1'b0;
            capture_irq <= 1'b0;
        end else begin
            overflow_irq <= overflow_flag_reg & irq_en_reg[`FLAG_OVF_BIT];
            capture_irq <= capture_flag_reg & irq_en_reg[`FLAG_CAP_BIT];
        end
    end

    // Control, compare and enable registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_reg <= `CTRL_RST;
            ctrl_b_reg <= `CTRL_RST;
            cmpa_reg <= `CNT_RST;
            cmpb_reg <= `CNT_RST;
            irq_en_reg <= `CTRL_RST;
            cap_cfg_reg <= `CTRL_RST;
        end else if (wr) begin
            case (paddr)
                `OFS_CTRL_A: ctrl_a_reg <= wbyte;
                `OFS_CTRL_B: ctrl_b_reg <= wbyte;
                `OFS_CMPA_LO: cmpa_reg <= {temp_reg, wbyte};
                `OFS_CMPB_LO: cmpb_reg <= {temp_reg, wbyte};
                `OFS_IRQ_EN: irq_en_reg <= wbyte & 8'h21;
                `OFS_CAP_CFG: cap_cfg_reg <= wbyte & 8'h01;
                default: ;
            endcase
        end
    end

    // Read data mux and address decode
    always @* begin
        rdata_next = 32'h00000000;
        mapped = 1'b1;
        case (paddr)
            `OFS_CTRL_A: rdata_next[7:0] = ctrl_a_reg;
            `OFS_CTRL_B: rdata_next[7:0] = ctrl_b_reg;
            `OFS_CNT_LO: rdata_next[7:0] = count_reg[7:0];
            `OFS_CNT_HI: rdata_next[7:0] = temp_reg;
            `OFS_CAP_LO: rdata_next[7:0] = capture_reg[7:0];
            `OFS_CAP_HI: rdata_next[7:0] = temp_reg;
            `OFS_CMPA_LO: rdata_next[7:0] = cmpa_reg[7:0];
            `OFS_CMPA_HI: rdata_next[7:0] = cmpa_reg[15:8];
            `OFS_CMPB_LO: rdata_next[7:0] = cmpb_reg[7:0];
            `OFS_CMPB_HI: rdata_next[7:0] = cmpb_reg[15:8];
            `OFS_FLAGS: begin
                rdata_next[`FLAG_OVF_BIT] = overflow_flag_reg;
                rdata_next[`FLAG_CAP_BIT] = capture_flag_reg;
            end
            `OFS_IRQ_EN: rdata_next[7:0] = irq_en_reg;
            `OFS_CAP_CFG: rdata_next[7:0] = cap_cfg_reg;
            default: mapped = 1'b0;
        endcase
    end

    // APB answer: one cycle after setup, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_cyc;
            pslverr <= setup_cyc & ~mapped;
            if (rd_setup) begin
                prdata <= rdata_next;
            end
        end
    end

endmodule // counter16_capture

// ### rtl/counter16_defs.vh
// Purpose: Offsets, field positions and reset values of the capture counter
// Assumes: APB byte addresses, one aligned word per register
// Notes: Byte-wide registers sit in bits 7:0, upper bits read as zero
`ifndef COUNTER16_DEFS_VH
`define COUNTER16_DEFS_VH

// Register byte offsets
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_CNT_LO 8'h08
`define OFS_CNT_HI 8'h0C
`define OFS_CAP_LO 8'h10
`define OFS_CAP_HI 8'h14
`define OFS_CMPA_LO 8'h18
`define OFS_CMPA_HI 8'h1C
`define OFS_CMPB_LO 8'h20
`define OFS_CMPB_HI 8'h24
`define OFS_FLAGS 8'h28
`define OFS_IRQ_EN 8'h2C
`define OFS_CAP_CFG 8'h30

// Field positions
`define A_WGM_MSB 1
`define A_WGM_LSB 0
`define B_CS_MSB 2
`define B_CS_LSB 0
`define B_WGM_MSB 4
`define B_WGM_LSB 3
`define B_EDGE_BIT 6
`define FLAG_OVF_BIT 0
`define FLAG_CAP_BIT 5
`define CFG_SRC_BIT 0

// Reset values and fixed counts
`define CTRL_RST 8'h00
`define CNT_RST 16'h0000
`define CNT_MAX 16'hFFFF
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define PRESC_W 10

`endif

// ### verif/counter16_capture_sva.sv
// Purpose: Port-level checks of the capture counter's APB answer
// Assumes: One clock, asynchronous active-low reset
// Notes: Sees only top-level ports
`timescale 1ns/1ps
module counter16_capture_sva #(
    parameter ADDR_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire capture_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Answer timing and framing
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Read data shape
    chk_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_err_zero_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_rdata_held: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read");
    // Address decode
    chk_err_map: assert property (pready |-> pslverr == (paddr > 'h30 || paddr[1:0] != 2'b00))
        else $error("error flag disagrees with map");

    // Main scenarios
    cov_read: cover property (pready && !pwrite);
    cov_write: cover property (pready && pwrite);
    cov_err: cover property (pready && pslverr);
    cov_cap: cover property ($rose(capture_irq));
endmodule // counter16_capture_sva

// ### verif/apb_host_model.sv
// Purpose: Processor-side APB master for the capture counter
// Assumes: Slave answers with pready, no fixed wait
// Notes: Wide registers go high first on writes, low first on reads
`timescale 1ns/1ps
module apb_host_model (
    input wire pclk,
    input wire [31:0] prdata,
    input wire pready,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [7:0] paddr,
    output reg [31:0] pwdata,
    output reg hung
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hung = 1'b0;
    end

    // One transfer; keep leaves psel up for a following setup
    task xfer(input bit w, input [7:0] a, input [7:0] d, input bit keep);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) hung <= 1'b1;
        if (!keep) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Wide write, high byte first into the shared byte
    task wr16(input [7:0] a, input [15:0] v);
        xfer(1'b1, a + 8'h04, v[15:8], 1'b1);
        xfer(1'b1, a, v[7:0], 1'b0);
    endtask

    // Wide read, low byte first
    task rd16(input [7:0] a, input [7:0] d);
        xfer(1'b0, a, d, 1'b1);
        xfer(1'b0, a + 8'h04, d, 1'b0);
    endtask
endmodule // apb_host_model

// ### verif/tb.sv
// Purpose: Self-checking bench for the capture counter
// Assumes: Host model drives APB, expectations queued per transfer
// Notes: External clock pin toggled only in the event-counting scenario
`timescale 1ns/1ps
`include "counter16_defs.vh"
module tb;
    logic pclk = 1'b0, presetn, ext_clock_pin, capture_pin, comparator_output;
    logic overflow_irq_ack, capture_irq_ack;
    wire psel, penable, pwrite, pready, pslverr, overflow_irq, capture_irq, at_top, at_bottom, hung;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    int errors = 0, checks = 0, seed = 94, r, n;
    logic [32:0] exp_q[$], e;
    logic [15:0] v, v2;

    always #2 pclk = ~pclk;

    counter16_capture u_counter16_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin), .comparator_output(comparator_output),
        .overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack), .overflow_irq(overflow_irq),
        .capture_irq(capture_irq), .at_top(at_top), .at_bottom(at_bottom));
    apb_host_model host (.pclk(pclk), .prdata(prdata), .pready(pready), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));

    task test_done;
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Queue the answer, then run the transfer
    task acc(input bit w, input [7:0] a, input [7:0] d, input [32:0] x);
        exp_q.push_back(x);
        host.xfer(w, a, d, 1'b0);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        acc(1'b1, a, d, 33'h0);
    endtask
    task rd(input [7:0] a, input [7:0] x);
        r = $random(seed);
        acc(1'b0, a, r[7:0], {25'h0, x});
    endtask
    task wr16(input [7:0] a, input [15:0] x);
        exp_q.push_back(33'h0);
        exp_q.push_back(33'h0);
        host.wr16(a, x);
    endtask
    task rd16(input [7:0] a, input [15:0] x);
        exp_q.push_back({25'h0, x[7:0]});
        exp_q.push_back({25'h0, x[15:8]});
        r = $random(seed);
        host.rd16(a, r[7:0]);
    endtask
    // Bounded wait on an output: 0 top, 1 bottom, 2 overflow irq, 3 capture irq
    task wt(input int s, input int lim);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            @(posedge pclk);
            n++;
            hit = ((s == 0 ? at_top : s == 1 ? at_bottom : s == 2 ? overflow_irq : capture_irq) === 1'b1);
        end
        if (!hit) begin
            errors++;
            $display("[ERR] wait %0d expected 1 seen 0", s);
            test_done;
        end
    endtask
    task ck(input [15:0] x, input [15:0] g);
        checks++;
        if (g !== x) begin
            errors++;
            $display("[ERR] cycle count expected %0d seen %0d", x, g);
        end
    endtask
    task pulse_ack(input bit cap);
        if (cap) capture_irq_ack <= 1'b1;
        else overflow_irq_ack <= 1'b1;
        @(posedge pclk);
        capture_irq_ack <= 1'b0;
        overflow_irq_ack <= 1'b0;
    endtask

    // Compare every APB answer with the oldest note
    always @(posedge pclk) if (pready === 1'b1) begin
        checks++;
        if (exp_q.size() == 0) begin
            errors++;
            $display("[ERR] apb answer expected none seen %h", {pslverr, prdata});
        end else begin
            e = exp_q.pop_front();
            if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0])) begin
                errors++;
                $display("[ERR] apb answer expected %h seen %h", e, {pslverr, prdata});
            end
        end
    end
    always @(posedge hung) begin
        errors++;
        $display("[ERR] apb ready expected 1 seen 0");
        test_done;
    end

    initial begin
        presetn = 1'b0;
        {ext_clock_pin, capture_pin, comparator_output, overflow_irq_ack, capture_irq_ack} = 5'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_CTRL_B, 8'h00);
        // Stopped counter keeps a written value
        r = $random(seed);
        v = r[15:0];
        wr16(`OFS_CNT_LO, v);
        repeat (6) @(posedge pclk);
        rd16(`OFS_CNT_LO, v);
        // Shared high byte
        wr(`OFS_CNT_HI, 8'h5A);
        wr(`OFS_CNT_LO, 8'h11);
        wr(`OFS_CMPA_LO, 8'h22);
        rd16(`OFS_CMPA_LO, 16'h5A22);
        wr(`OFS_CNT_HI, 8'hC3);
        rd(`OFS_CMPA_HI, 8'h5A);
        rd(`OFS_CAP_LO, 8'h00);
        rd(`OFS_CNT_HI, 8'h00);
        // Up count wraps from all ones to zero
        wr(`OFS_IRQ_EN, 8'h21);
        wr16(`OFS_CNT_LO, 16'hFFF0);
        wr(`OFS_CTRL_B, 8'h01);
        wt(0, 40);
        wt(1, 5);
        ck(16'd1, n[15:0]);
        wt(2, 10);
        wr(`OFS_CTRL_B, 8'h00);
        rd(`OFS_FLAGS, 8'h01);
        pulse_ack(1'b0);
        rd(`OFS_FLAGS, 8'h00);
        // Dual slope to 00FF and back down
        wr(`OFS_CTRL_A, 8'h01);
        wr16(`OFS_CNT_LO, 16'h00FE);
        wr(`OFS_CTRL_B, 8'h01);
        wt(0, 20);
        wt(1, 400);
        ck(16'd255, n[15:0]);
        wr(`OFS_CTRL_B, 8'h00);
        wr(`OFS_CTRL_A, 8'h00);
        rd(`OFS_FLAGS, 8'h01);
        wr(`OFS_FLAGS, 8'h01);
        rd(`OFS_FLAGS, 8'h00);
        // Capture on rising pin edge
        r = $random(seed);
        v = r[15:0];
        wr16(`OFS_CNT_LO, v);
        wr(`OFS_CTRL_B, 8'h40);
        capture_pin <= 1'b1;
        wt(3, 20);
        rd16(`OFS_CAP_LO, v);
        rd(`OFS_FLAGS, 8'h20);
        pulse_ack(1'b1);
        rd(`OFS_FLAGS, 8'h00);
        // Falling edge ignored, value held
        r = $random(seed);
        v2 = r[15:0];
        wr16(`OFS_CNT_LO, v2);
        capture_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        rd16(`OFS_CAP_LO, v);
        // Comparator as source
        wr(`OFS_CAP_CFG, 8'h01);
        comparator_output <= 1'b1;
        wt(3, 20);
        rd16(`OFS_CAP_LO, v2);
        wr(`OFS_FLAGS, 8'h20);
        rd(`OFS_FLAGS, 8'h00);
        // External pin rising edges as timer clock
        wr16(`OFS_CNT_LO, 16'h0000);
        wr(`OFS_CTRL_B, 8'h07);
        repeat (5) begin
            ext_clock_pin <= 1'b1;
            repeat (6) @(posedge pclk);
            ext_clock_pin <= 1'b0;
            repeat (6) @(posedge pclk);
        end
        wr(`OFS_CTRL_B, 8'h00);
        rd16(`OFS_CNT_LO, 16'h0005);
        // Falling comparator edge captures when edge bit is zero
        comparator_output <= 1'b0;
        wt(3, 20);
        rd16(`OFS_CAP_LO, 16'h0005);
        wr(`OFS_FLAGS, 8'h20);
        rd(`OFS_FLAGS, 8'h00);
        // Unmapped places refused
        acc(1'b0, 8'h34, 8'h00, {1'b1, 32'h0});
        acc(1'b1, 8'h3C, 8'hFF, {1'b1, 32'h0});
        repeat (4) @(posedge pclk);
        if (exp_q.size() != 0) begin
            errors++;
            $display("[ERR] answers left expected 0 seen %0d", exp_q.size());
        end
        test_done;
    end
endmodule // tb

bind counter16_capture counter16_capture_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_irq(capture_irq));
